// File: ddcsc_pkg.sv
// package of constants and types for the ddc routing and oscillator sync control
package ddcsc_pkg;

    // ------------------------------------------------------------------
    // bus geometry
    // ------------------------------------------------------------------
    localparam int unsigned ADDR_W   = 12;
    localparam int unsigned IDX_W    = 10;
    localparam int unsigned APB_W    = 32;
    localparam int unsigned STRB_W   = 4;
    localparam int unsigned REG8_W   = 8;
    localparam int unsigned RDIV_W   = 16;
    localparam logic [1:0]  WORD_ALIGN = 2'h0;

    // ------------------------------------------------------------------
    // register indices, byte address is four times the index
    // ------------------------------------------------------------------
    localparam logic [IDX_W-1:0] IDX_ROUTE  = 10'h216;
    localparam logic [IDX_W-1:0] IDX_RDIV   = 10'h217;
    localparam logic [IDX_W-1:0] IDX_SYNC   = 10'h219;
    localparam logic [IDX_W-1:0] IDX_LINK   = 10'h21A;
    localparam logic [IDX_W-1:0] IDX_STATUS = 10'h21B;

    // ------------------------------------------------------------------
    // field positions
    // ------------------------------------------------------------------
    localparam int unsigned ROUTE_A_BIT   = 0;
    localparam int unsigned ROUTE_B_BIT   = 1;
    localparam int unsigned SYNC_NEXT_BIT = 0;
    localparam int unsigned SYNC_ILA_BIT  = 1;
    localparam int unsigned LINK_EN_BIT   = 0;
    localparam int unsigned CAL_EN_BIT    = 1;
    localparam int unsigned PD_A_BIT      = 2;
    localparam int unsigned PD_B_BIT      = 3;
    localparam int unsigned LANE_W        = 8;

    // ------------------------------------------------------------------
    // reset values
    // ------------------------------------------------------------------
    localparam logic [REG8_W-1:0] ROUTE_RST = 8'h02;
    localparam logic [RDIV_W-1:0] RDIV_RST  = 16'h0000;
    localparam logic [REG8_W-1:0] SYNC_RST  = 8'h02;
    localparam logic [REG8_W-1:0] LINK_RST  = 8'h00;
    localparam logic [APB_W-1:0]  DATA_ZERO = 32'h0000_0000;

    // ------------------------------------------------------------------
    // types
    // ------------------------------------------------------------------
    typedef enum logic [1:0] {
        ARM_IDLE    = 2'b00,
        ARM_CLEARED = 2'b01,
        ARM_ARMED   = 2'b10,
        ARM_DONE    = 2'b11
    } ddcsc_arm_state_t;

    typedef struct packed {
        logic src_b;
        logic pd;
    } ddcsc_chan_t;

    typedef struct packed {
        logic [3:0]       rsvd;
        ddcsc_arm_state_t state;
        logic             pd_b;
        logic             pd_a;
        logic             done;
        logic             armed;
    } ddcsc_status_t;

endpackage

// File: ddcsc_pin_sync.sv
// three-stage pin synchroniser with agreement filter and rise detector
`timescale 1ns/10ps
module ddcsc_pin_sync (
    input  wire logic clock,
    input  wire logic rst,
    input  wire logic pin_in,
    output logic      level,
    output logic      rise
);
    logic s1_reg;
    logic s2_reg;
    logic s3_reg;

    // ------------------------------------------------------------------
    // metastability chain, first stage feeds only the second
    // ------------------------------------------------------------------
    always_ff @(posedge clock) begin
        if (rst) begin
            s1_reg <= 1'b0;
            s2_reg <= 1'b0;
            s3_reg <= 1'b0;
        end else begin
            s1_reg <= pin_in;
            s2_reg <= s1_reg;
            s3_reg <= s2_reg;
        end
    end

    // level moves only when stages two and three agree
    always_ff @(posedge clock) begin
        if (rst) begin
            level <= 1'b0;
            rise  <= 1'b0;
        end else begin
            if (s2_reg == s3_reg) begin
                level <= s2_reg;
            end
            rise <= (s2_reg == s3_reg) && s2_reg && !level;
        end
    end
endmodule

// File: ddcsc_chan_route.sv
// one digital channel: core select and power-down inheritance
`timescale 1ns/10ps
module ddcsc_chan_route
    import ddcsc_pkg::*;
#(
    parameter int unsigned DATA_W = 12
) (
    input  wire logic              clock,
    input  wire logic              rst,
    input  wire logic              src_b,
    input  wire logic              adc_a_powerdown,
    input  wire logic              adc_b_powerdown,
    input  wire logic [DATA_W-1:0] core_a_data,
    input  wire logic [DATA_W-1:0] core_b_data,
    output ddcsc_chan_t            chan_state,
    output logic [DATA_W-1:0]      chan_data
);
    logic bound_pd;

    // channel inherits the power state of the core it is bound to
    assign bound_pd = src_b ? adc_b_powerdown : adc_a_powerdown;

    // ------------------------------------------------------------------
    // registered select; a powered-down channel outputs zero
    // ------------------------------------------------------------------
    always_ff @(posedge clock) begin
        if (rst) begin
            chan_state <= '0;
            chan_data  <= '0;
        end else begin
            chan_state.src_b <= src_b;
            chan_state.pd    <= bound_pd;
            if (bound_pd) begin
                chan_data <= '0;
            end else begin
                chan_data <= src_b ? core_b_data : core_a_data;
            end
        end
    end
endmodule

// File: ddcsc_top.sv
// ddc channel routing, rational divisor and oscillator phase sync control
//
// Summary of operation
// - channel B from core A at 0, B at 1
// - channel A from core A at 0, B at 1
// - channel powers down with its bound core
// - hold 16-bit rational reference divisor
// - one divisor shared by every preset
// - align-sequence bit: init phase at ila start
// - write 0 then 1 arms sysref init
// - after sysref init ignore edges until rearmed
// - first sysref rise after arming inits phase
//
// The APB interface to the registers was left to the implementer.
`timescale 1ns/10ps
module ddcsc_top
    import ddcsc_pkg::*;
#(
    parameter int unsigned DATA_W = 12
) (
    input  wire logic              clock,
    input  wire logic              rst,
    // apb slave
    input  wire logic              psel,
    input  wire logic              penable,
    input  wire logic              pwrite,
    input  wire logic [ADDR_W-1:0] paddr,
    input  wire logic [APB_W-1:0]  pwdata,
    input  wire logic [STRB_W-1:0] pstrb,
    output logic [APB_W-1:0]       prdata,
    output logic                   pready,
    output logic                   pslverr,
    // sync sources
    input  wire logic              sysref_pin,
    input  wire logic              ila_lmfc_start,
    // converter cores and channels
    input  wire logic [DATA_W-1:0] core_a_data,
    input  wire logic [DATA_W-1:0] core_b_data,
    output logic [DATA_W-1:0]      chan_a_data,
    output logic [DATA_W-1:0]      chan_b_data,
    output ddcsc_chan_t            chan_a_state,
    output ddcsc_chan_t            chan_b_state,
    // control outputs
    output logic [RDIV_W-1:0]      rational_ref_divisor,
    output logic                   phase_init_pulse,
    output logic                   serial_link_enable,
    output logic                   calibration_enable,
    output logic                   adc_a_powerdown,
    output logic                   adc_b_powerdown
);

    // ------------------------------------------------------------------
    // decode helpers
    // ------------------------------------------------------------------
    // word-aligned hit on a register index
    function automatic logic reg_hit(input logic [ADDR_W-1:0] addr,
                                     input logic [IDX_W-1:0]  idx);
        reg_hit = (addr[ADDR_W-1:2] == idx) && (addr[1:0] == WORD_ALIGN);
    endfunction

    // merge one byte lane under its strobe
    function automatic logic [LANE_W-1:0] lane_merge(input logic [LANE_W-1:0] old,
                                                     input logic [LANE_W-1:0] wdat,
                                                     input logic              strb);
        lane_merge = strb ? wdat : old;
    endfunction

    // ------------------------------------------------------------------
    // storage
    // ------------------------------------------------------------------
    logic [REG8_W-1:0]  route_reg;
    logic [RDIV_W-1:0]  rdiv_reg;
    logic [REG8_W-1:0]  sync_reg;
    logic [REG8_W-1:0]  link_reg;
    logic [APB_W-1:0]   prdata_reg;
    logic               phase_init_reg;
    ddcsc_arm_state_t   arm_reg;
    ddcsc_arm_state_t   arm_next;
    ddcsc_status_t      status;

    logic               access;
    logic               wr_en;
    logic               rd_setup;
    logic               hit_route;
    logic               hit_rdiv;
    logic               hit_sync;
    logic               hit_link;
    logic               hit_status;
    logic               mapped;
    logic               wr_next_bit;
    logic               next_val;
    logic               sysref_rise;
    logic               sysref_fire;
    logic               ila_fire;
    logic [APB_W-1:0]   rd_data;

    // ------------------------------------------------------------------
    // apb decode
    // ------------------------------------------------------------------
    // zero-wait slave: every access phase completes in its first cycle
    assign access     = psel && penable;
    assign wr_en      = access && pwrite;
    assign rd_setup   = psel && !penable && !pwrite;
    assign hit_route  = reg_hit(paddr, IDX_ROUTE);
    assign hit_rdiv   = reg_hit(paddr, IDX_RDIV);
    assign hit_sync   = reg_hit(paddr, IDX_SYNC);
    assign hit_link   = reg_hit(paddr, IDX_LINK);
    assign hit_status = reg_hit(paddr, IDX_STATUS);
    assign mapped     = hit_route || hit_rdiv || hit_sync || hit_link || hit_status;
    assign pready     = 1'b1;
    assign pslverr    = access && !mapped;  // unmapped word answers with an error
    assign prdata     = prdata_reg;

    // ------------------------------------------------------------------
    // writable registers
    // ------------------------------------------------------------------
    // routing register keeps all eight bits; only the low two steer
    always_ff @(posedge clock) begin
        if (rst) begin
            route_reg <= ROUTE_RST;
        end else if (wr_en && hit_route) begin
            route_reg <= lane_merge(route_reg, pwdata[7:0], pstrb[0]);
        end
    end

    // single divisor word, two byte lanes
    always_ff @(posedge clock) begin
        if (rst) begin
            rdiv_reg <= RDIV_RST;
        end else if (wr_en && hit_rdiv) begin
            rdiv_reg[7:0]  <= lane_merge(rdiv_reg[7:0], pwdata[7:0], pstrb[0]);
            rdiv_reg[15:8] <= lane_merge(rdiv_reg[15:8], pwdata[15:8], pstrb[1]);
        end
    end

    // sync control; reserved bits are kept but never decoded
    always_ff @(posedge clock) begin
        if (rst) begin
            sync_reg <= SYNC_RST;
        end else if (wr_en && hit_sync) begin
            sync_reg <= lane_merge(sync_reg, pwdata[7:0], pstrb[0]);
        end
    end

    // link, calibration and core power-down controls
    always_ff @(posedge clock) begin
        if (rst) begin
            link_reg <= LINK_RST;
        end else if (wr_en && hit_link) begin
            link_reg <= lane_merge(link_reg, pwdata[7:0], pstrb[0]);
        end
    end

    assign serial_link_enable   = link_reg[LINK_EN_BIT];
    assign calibration_enable   = link_reg[CAL_EN_BIT];
    assign adc_a_powerdown      = link_reg[PD_A_BIT];
    assign adc_b_powerdown      = link_reg[PD_B_BIT];
    // one divisor feeds every preset, so no per-preset copies exist
    assign rational_ref_divisor = rdiv_reg;

    // ------------------------------------------------------------------
    // sysref input
    // ------------------------------------------------------------------
    ddcsc_pin_sync u_sysref (
        .clock  (clock),
        .rst    (rst),
        .pin_in (sysref_pin),
        .level  (),
        .rise   (sysref_rise)
    );

    // ------------------------------------------------------------------
    // arming sequence
    // ------------------------------------------------------------------
    // only a byte-lane-0 write to the sync word counts as a rewrite
    assign wr_next_bit = wr_en && hit_sync && pstrb[0];
    assign next_val    = pwdata[SYNC_NEXT_BIT];
    // an edge in the same cycle as a clearing write still fires
    assign sysref_fire = (arm_reg == ARM_ARMED) && sysref_rise;
    assign ila_fire    = sync_reg[SYNC_ILA_BIT] && ila_lmfc_start;

    // a 0 must be seen before a 1 arms; reset counts as no write
    always_comb begin
        arm_next = arm_reg;
        unique case (arm_reg)
            ARM_IDLE: begin
                if (wr_next_bit && !next_val) begin
                    arm_next = ARM_CLEARED;
                end
            end
            ARM_CLEARED: begin
                if (wr_next_bit && next_val) begin
                    arm_next = ARM_ARMED;
                end
            end
            ARM_ARMED: begin
                if (wr_next_bit && !next_val) begin
                    arm_next = ARM_CLEARED;
                end else if (sysref_rise) begin
                    arm_next = ARM_DONE;
                end
            end
            ARM_DONE: begin
                // later edges are ignored; writing 1 alone does not rearm
                if (wr_next_bit && !next_val) begin
                    arm_next = ARM_CLEARED;
                end
            end
        endcase
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            arm_reg <= ARM_IDLE;
        end else begin
            arm_reg <= arm_next;
        end
    end

    // phase initialise strobe to both oscillators
    always_ff @(posedge clock) begin
        if (rst) begin
            phase_init_reg <= 1'b0;
        end else begin
            phase_init_reg <= sysref_fire || ila_fire;
        end
    end

    assign phase_init_pulse = phase_init_reg;

    // ------------------------------------------------------------------
    // channel routing
    // ------------------------------------------------------------------
    // routing is not interlocked with the link enable; software sequences it
    ddcsc_chan_route #(
        .DATA_W (DATA_W)
    ) u_chan_a (
        .clock           (clock),
        .rst             (rst),
        .src_b           (route_reg[ROUTE_A_BIT]),
        .adc_a_powerdown (adc_a_powerdown),
        .adc_b_powerdown (adc_b_powerdown),
        .core_a_data     (core_a_data),
        .core_b_data     (core_b_data),
        .chan_state      (chan_a_state),
        .chan_data       (chan_a_data)
    );

    ddcsc_chan_route #(
        .DATA_W (DATA_W)
    ) u_chan_b (
        .clock           (clock),
        .rst             (rst),
        .src_b           (route_reg[ROUTE_B_BIT]),
        .adc_a_powerdown (adc_a_powerdown),
        .adc_b_powerdown (adc_b_powerdown),
        .core_a_data     (core_a_data),
        .core_b_data     (core_b_data),
        .chan_state      (chan_b_state),
        .chan_data       (chan_b_data)
    );

    // ------------------------------------------------------------------
    // status and read path
    // ------------------------------------------------------------------
    always_comb begin
        status       = '0;
        status.armed = (arm_reg == ARM_ARMED);
        status.done  = (arm_reg == ARM_DONE);
        status.pd_a  = chan_a_state.pd;
        status.pd_b  = chan_b_state.pd;
        status.state = arm_reg;
    end

    // narrow registers sit in the low bits, upper bits read zero
    always_comb begin
        rd_data = DATA_ZERO;
        if (hit_route) begin
            rd_data[REG8_W-1:0] = route_reg;
        end else if (hit_rdiv) begin
            rd_data[RDIV_W-1:0] = rdiv_reg;
        end else if (hit_sync) begin
            rd_data[REG8_W-1:0] = sync_reg;
        end else if (hit_link) begin
            rd_data[REG8_W-1:0] = link_reg;
        end else if (hit_status) begin
            rd_data[REG8_W-1:0] = status[REG8_W-1:0];
        end
    end

    // read data captured in setup so it is a flop during access
    always_ff @(posedge clock) begin
        if (rst) begin
            prdata_reg <= DATA_ZERO;
        end else if (rd_setup) begin
            prdata_reg <= rd_data;
        end
    end

endmodule

// File: ddcsc_chk_sva.sv
// port-level assertions for the ddc routing and phase sync control
`timescale 1ns/10ps
module ddcsc_chk
    import ddcsc_pkg::*;
#(
    parameter int unsigned DATA_W = 12
) (
    input wire logic              clock,
    input wire logic              rst,
    input wire logic              psel,
    input wire logic              penable,
    input wire logic              pwrite,
    input wire logic [ADDR_W-1:0] paddr,
    input wire logic [APB_W-1:0]  pwdata,
    input wire logic [STRB_W-1:0] pstrb,
    input wire logic              pslverr,
    input wire logic              sysref_pin,
    input wire logic              ila_lmfc_start,
    input wire logic [DATA_W-1:0] core_a_data,
    input wire logic [DATA_W-1:0] core_b_data,
    input wire logic [DATA_W-1:0] chan_a_data,
    input wire ddcsc_chan_t       chan_a_state,
    input wire ddcsc_chan_t       chan_b_state,
    input wire logic [RDIV_W-1:0] rational_ref_divisor,
    input wire logic              phase_init_pulse,
    input wire logic              adc_a_powerdown,
    input wire logic              adc_b_powerdown
);
    localparam logic [ADDR_W-1:0] A_ROUTE = {IDX_ROUTE, WORD_ALIGN};
    localparam logic [ADDR_W-1:0] A_RDIV  = {IDX_RDIV, WORD_ALIGN};
    localparam logic [ADDR_W-1:0] A_SYNC  = {IDX_SYNC, WORD_ALIGN};
    logic ila_q;
    logic ila_en_reg;
    logic used_reg;
    wire  sync_wr = psel && penable && pwrite && paddr == A_SYNC && pstrb[0];

    default clocking cb @(posedge clock); endclocking
    default disable iff (rst);

    // ------------
    // shadow state
    // ------------
    // align enable follows lane-0 writes to the sync register
    always_ff @(posedge clock) begin
        if (rst) begin
            ila_en_reg <= 1'b1;
        end else if (sync_wr) begin
            ila_en_reg <= pwdata[SYNC_ILA_BIT];
        end
    end
    // a sysref init spends the arm until software rewrites it
    always_ff @(posedge clock) begin
        ila_q <= ila_lmfc_start;
        if (rst || sync_wr) begin
            used_reg <= 1'b0;
        end else if (phase_init_pulse && !ila_q) begin
            used_reg <= 1'b1;
        end
    end

    // ----------
    // properties
    // ----------
    sequence s_wr(a);
        psel && penable && pwrite && paddr == a && pstrb[0];
    endsequence
    property p_route_a;
        s_wr(A_ROUTE) |-> ##2 chan_a_state.src_b == $past(pwdata[ROUTE_A_BIT], 2);
    endproperty
    a_route_a: assert property (p_route_a) else $error("channel a source wrong");
    property p_route_b;
        s_wr(A_ROUTE) |-> ##2 chan_b_state.src_b == $past(pwdata[ROUTE_B_BIT], 2);
    endproperty
    a_route_b: assert property (p_route_b) else $error("channel b source wrong");
    property p_pd_a;
        chan_a_state.pd == (chan_a_state.src_b ? $past(adc_b_powerdown) : $past(adc_a_powerdown));
    endproperty
    a_pd_a: assert property (p_pd_a) else $error("channel a power-down wrong");
    property p_pd_b;
        chan_b_state.pd == (chan_b_state.src_b ? $past(adc_b_powerdown) : $past(adc_a_powerdown));
    endproperty
    a_pd_b: assert property (p_pd_b) else $error("channel b power-down wrong");
    property p_data_a;
        !$past(rst) |-> chan_a_data == (chan_a_state.pd ? {DATA_W{1'b0}} :
            (chan_a_state.src_b ? $past(core_b_data) : $past(core_a_data)));
    endproperty
    a_data_a: assert property (p_data_a) else $error("channel a data wrong");
    property p_rdiv;
        s_wr(A_RDIV) ##0 pstrb[1] |=> rational_ref_divisor == $past(pwdata[RDIV_W-1:0]);
    endproperty
    a_rdiv: assert property (p_rdiv) else $error("divisor not taken");
    property p_ila;
        ila_lmfc_start && ila_en_reg |=> phase_init_pulse;
    endproperty
    a_ila: assert property (p_ila) else $error("no init at align start");
    property p_cause;
        phase_init_pulse |-> $past(ila_lmfc_start) || $past(sysref_pin, 3);
    endproperty
    a_cause: assert property (p_cause) else $error("init without cause");
    property p_once;
        phase_init_pulse && used_reg |-> $past(ila_lmfc_start);
    endproperty
    a_once: assert property (p_once) else $error("second sysref init");
    property p_one;
        phase_init_pulse && !ila_lmfc_start |=> !phase_init_pulse;
    endproperty
    a_one: assert property (p_one) else $error("init pulse too long");
endmodule

// File: ddcsc_sysref_src.sv
// sysref source model: idle low, one wide pulse per command
`timescale 1ns/10ps
module ddcsc_sysref_src (
    input  wire logic       clock,
    input  wire logic       fire,
    input  wire logic [3:0] gap,
    output logic            sysref_pin
);
    logic [4:0] cnt_reg = 5'h00;
    logic [4:0] cnt_next;

    // ------------
    // pulse timing
    // ------------
    // gap cycles of delay, then six high so the pin filter sees it
    assign cnt_next = fire ? {1'b0, gap} + 5'h06 :
                      (cnt_reg != 5'h00 ? cnt_reg - 5'h01 : 5'h00);
    always_ff @(posedge clock) begin
        cnt_reg <= cnt_next;
    end
    // low between commands: a stray edge would spend an armed device
    assign sysref_pin = (cnt_reg != 5'h00) && (cnt_reg <= 5'h06);
endmodule

// File: tb_top.sv
// testbench for the ddc routing, divisor and phase sync control
`timescale 1ns/10ps
module tb_top
    import ddcsc_pkg::*;
;
    localparam int DW = 12;
    localparam logic [ADDR_W-1:0] A_ROUTE = {IDX_ROUTE, WORD_ALIGN};
    localparam logic [ADDR_W-1:0] A_RDIV  = {IDX_RDIV, WORD_ALIGN};
    localparam logic [ADDR_W-1:0] A_SYNC  = {IDX_SYNC, WORD_ALIGN};
    localparam logic [ADDR_W-1:0] A_LINK  = {IDX_LINK, WORD_ALIGN};
    typedef struct packed {
        logic [7:0]  route;
        logic [7:0]  link;
        ddcsc_chan_t exp_a;
        ddcsc_chan_t exp_b;
    } ddcsc_row_t;
    logic              clock, rst, psel, penable, pwrite, ila_lmfc_start, fire, err;
    logic              pready, pslverr, sysref_pin, phase_init_pulse;
    logic [ADDR_W-1:0] paddr;
    logic [APB_W-1:0]  pwdata, prdata, rdat;
    logic [STRB_W-1:0] pstrb;
    logic [3:0]        gap;
    logic [DW-1:0]     core_a, core_b, chan_a_data, chan_b_data;
    logic [RDIV_W-1:0] rdiv;
    ddcsc_chan_t       st_a, st_b;
    int                fail_count, compares, pulses;
    // route, link, expected {src_b, pd} of channels a and b
    ddcsc_row_t        rows [6] = '{'{8'h02, 8'h00, 2'h0, 2'h2}, '{8'h00, 8'h04, 2'h1, 2'h1},
        '{8'h03, 8'h04, 2'h2, 2'h2}, '{8'h01, 8'h08, 2'h3, 2'h0},
        '{8'hFE, 8'h08, 2'h0, 2'h3}, '{8'hFD, 8'h0C, 2'h3, 2'h1}};

    ddcsc_top #(.DATA_W(DW)) dut_u (
        .clock, .rst, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb, .prdata,
        .pready, .pslverr, .sysref_pin, .ila_lmfc_start, .core_a_data(core_a),
        .core_b_data(core_b), .chan_a_data, .chan_b_data, .chan_a_state(st_a),
        .chan_b_state(st_b), .rational_ref_divisor(rdiv), .phase_init_pulse,
        .serial_link_enable(), .calibration_enable(), .adc_a_powerdown(),
        .adc_b_powerdown()
    );
    ddcsc_sysref_src src_u (.clock, .fire, .gap, .sysref_pin);

    // -----------------
    // clock and helpers
    // -----------------
    initial begin
        clock = 1'b0;
        forever #2.5 clock = ~clock;
    end
    // counting pulses avoids racing the one-cycle pulse at its edge
    always @(posedge clock) begin
        if (phase_init_pulse === 1'b1)
            pulses <= pulses + 1;
    end
    task automatic print_verdict();
        $display("compares %0d mismatches %0d", compares, fail_count);
        if (fail_count == 0 && compares > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    task automatic check(input logic [APB_W-1:0] seen, input logic [APB_W-1:0] exp);
        compares++;
        if (seen !== exp) begin
            fail_count++;
            $display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge clock);
    endtask
    // one apb transfer; entered and left after a rising edge
    task automatic apb(input logic w, input logic [ADDR_W-1:0] a,
                       input logic [APB_W-1:0] d, input logic [STRB_W-1:0] s);
        int n;
        @(posedge clock);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        pstrb <= s;
        @(posedge clock);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge clock);
            n++;
        end while (pready !== 1'b1 && n < 20);
        rdat = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (pready !== 1'b1) begin
            fail_count++;
            print_verdict();
        end
    endtask
    function automatic logic [DW-1:0] expd(input ddcsc_chan_t s);
        return s.pd ? {DW{1'b0}} : (s.src_b ? core_b : core_a);
    endfunction
    task automatic ila_try(input int exp);
        int base;
        base = pulses;
        ila_lmfc_start <= 1'b1;
        @(posedge clock);
        ila_lmfc_start <= 1'b0;
        tick(3);
        check(32'(pulses - base), 32'(exp));
    endtask
    task automatic sref(input logic [3:0] g, input int exp);
        int base;
        base = pulses;
        gap <= g;
        fire <= 1'b1;
        @(posedge clock);
        fire <= 1'b0;
        tick(30);
        check(32'(pulses - base), 32'(exp));
    endtask

    // -------------
    // main sequence
    // -------------
    initial begin
        rst = 1'b1;
        {psel, penable, pwrite, ila_lmfc_start, fire} = 5'h00;
        {paddr, pwdata, pstrb, gap} = '0;
        core_a = 12'h0A5;
        core_b = 12'h35A;
        {fail_count, compares, pulses} = '0;
        tick(5);
        rst <= 1'b0;
        // link and cal cleared before every reroute
        foreach (rows[i]) begin
            apb(1'b1, A_LINK, 32'h0, 4'hF);
            apb(1'b1, A_ROUTE, {24'h0, rows[i].route}, 4'hF);
            apb(1'b1, A_LINK, {24'h0, rows[i].link}, 4'hF);
            tick(2);
            check(st_a, rows[i].exp_a);
            check(st_b, rows[i].exp_b);
            check(chan_a_data, expd(rows[i].exp_a));
            check(chan_b_data, expd(rows[i].exp_b));
            apb(1'b0, A_ROUTE, 32'h0, 4'h0);
            check(rdat, {24'h0, rows[i].route});
        end
        $display("routing table done");
        rst <= 1'b1;
        tick(5);
        rst <= 1'b0;
        apb(1'b0, A_ROUTE, 32'h0, 4'h0);
        check(rdat, 32'h0000_0002);
        apb(1'b0, A_SYNC, 32'h0, 4'h0);
        check(rdat, 32'h0000_0002);
        check({st_a, st_b, rdiv}, {2'h0, 2'h2, 16'h0000});
        $display("mid-run reset done");
        apb(1'b1, A_RDIV, 32'h1234_ABCD, 4'hF);
        tick(1);
        check(rdiv, 16'hABCD);
        apb(1'b1, A_RDIV, 32'h0000_0077, 4'h1);
        apb(1'b0, A_RDIV, 32'h0, 4'h0);
        check(rdat, 32'h0000_AB77);
        apb(1'b0, 12'h860, 32'h0, 4'h0);
        check(32'(err), 32'h1);
        check(rdat, 32'h0);
        $display("divisor and unmapped done");
        ila_try(1);
        // sysref is ignored until 0 then 1 is written
        apb(1'b1, A_LINK, 32'h1, 4'h1);
        apb(1'b1, A_SYNC, 32'h0000_0000, 4'h1);
        ila_try(0);
        sref(4'h0, 0);
        apb(1'b1, A_SYNC, 32'h0000_0001, 4'h1);
        sref(4'h0, 1);
        sref(4'h5, 0);
        apb(1'b1, A_SYNC, 32'h0000_0000, 4'h1);
        apb(1'b1, A_SYNC, 32'h0000_00FD, 4'h1);
        sref(4'h9, 1);
        apb(1'b0, A_SYNC, 32'h0, 4'h0);
        check(rdat, 32'h0000_00FD);
        ila_try(0);
        apb(1'b0, 12'h86C, 32'h0, 4'h0);
        check(rdat, 32'h0000_0032);
        $display("phase init done");
        print_verdict();
    end
endmodule

bind ddcsc_top ddcsc_chk #(.DATA_W(DATA_W)) chk_u (
    .clock, .rst, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb, .pslverr,
    .sysref_pin, .ila_lmfc_start, .core_a_data, .core_b_data, .chan_a_data,
    .chan_a_state, .chan_b_state, .rational_ref_divisor, .phase_init_pulse,
    .adc_a_powerdown, .adc_b_powerdown
);
